// ==== design/mfre_pkg.sv ====
// constants and types of the multi-line fast read engine
package mfre_pkg;
  // ==========================================================
  // instruction codes
  localparam logic [7:0] CMD_QUAD_OUT = 8'h6B;
  localparam logic [7:0] CMD_DUAL_IO = 8'hBB;
  localparam logic [7:0] CMD_QUAD_IO = 8'hEB;
  localparam logic [7:0] CMD_WORD_QIO = 8'hE7;
  // ==========================================================
  // phase lengths in serial clocks, minus one
  localparam logic [4:0] CMD_CLK_SINGLE = 5'h07;
  localparam logic [4:0] CMD_CLK_QUAD = 5'h01;
  localparam logic [4:0] ADDR_CLK_X1 = 5'h17;
  localparam logic [4:0] ADDR_CLK_X2 = 5'h0B;
  localparam logic [4:0] ADDR_CLK_X4 = 5'h05;
  localparam logic [4:0] MODE_CLK_X2 = 5'h03;
  localparam logic [4:0] MODE_CLK_X4 = 5'h01;
  localparam logic [4:0] DUMMY_QUAD_OUT = 5'h07;
  localparam logic [4:0] DUMMY_QUAD_IO = 5'h03;
  localparam logic [4:0] DUMMY_WORD_QIO = 5'h01;
  localparam logic [2:0] OUT_BEATS_X2 = 3'h3;
  localparam logic [2:0] OUT_BEATS_X4 = 3'h1;
  // ==========================================================
  // fields and reset values
  localparam logic [1:0] CONT_KEEP = 2'b10;
  localparam int MODE_SEL_LSB = 4;
  localparam int WRAP_DIS_POS = 0;
  localparam int WRAP_LEN_LSB = 1;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam logic [1:0] RDPARAM_RESET = 2'h0;
  localparam logic [8:0] WRAP_MIN_LEN = 9'h008;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;
  localparam logic [3:0] OE_X2 = 4'h3;
  localparam logic [3:0] OE_X4 = 4'hF;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h2,
    ST_MODE = 3'h3,
    ST_DUMMY = 3'h4,
    ST_DATA = 3'h5,
    ST_IGN = 3'h6
  } mfre_state_t;
  typedef enum logic [1:0] {
    LW_X1 = 2'h0,
    LW_X2 = 2'h1,
    LW_X4 = 2'h2
  } mfre_width_t;
endpackage

// ==== design/mfre_engine.sv ====
// multi-line fast read engine of a serial flash device
`timescale 1ns/100ps
// Functional notes
// - quad output read needs quad permit bit
// - quad output: 24-bit address single line, eight dummies
// - lane values ignored during dummies, host releases
// - quad output, dual io refused in four-wire mode
// - dual io: address two bits per clock
// - mode byte follows address, only bits 5:4 used
// - select pair 10: next frame skips instruction
// - other select pair leaves continuous mode
// - quad io: four-lane address, four dummies
// - quad io read needs quad permit bit
// - wrap stays inside aligned section until deselect
// - wrap settings: disable bit plus length field
// - four-wire dummy count 2/4/6/8, default 2
// - four-wire mode byte counts as dummy
// - continuous mode also works in four-wire mode
// - no wrap in four-wire mode
// - word read: even address (address bit 0 not forced or checked), two dummies
// - word read needs permit, supports continuous mode
// - bytes msb first, address advances per byte
// - wrap disable bit resets to one
module mfre_engine #(
  parameter int BUF_DEPTH = 2,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // serial pins
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic [3:0] serial_lane_i,
  output logic [3:0] serial_lane_o,
  output logic [3:0] serial_lane_oe_o,
  // configuration
  input wire logic quad_lane_permit_bit_i,
  input wire logic four_wire_command_mode_i,
  input wire logic wrap_load_i,
  input wire logic [2:0] wrap_settings_i,
  input wire logic read_param_load_i,
  input wire logic [1:0] read_param_i,
  // status
  output logic read_active_o,
  output logic execute_in_place_o,
  output logic [2:0] wrap_settings_o,
  output logic [1:0] read_param_o,
  // array read port
  output logic mem_req_o,
  output logic [23:0] mem_addr_o,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  output logic mem_rready_o
);
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0 || DATA_W != 8) begin : g_check
    $error("mfre_engine: unsupported buffer depth or data width");
  end

  // ==========================================================
  // pin synchronisers
  logic cs_s1_r, cs_s2_r, ck_s1_r, ck_s2_r, ck_s3_r;
  logic [3:0] ln_s1_r, ln_s2_r;
  logic rise_w, fall_w;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      ln_s1_r <= 4'h0;
      ln_s2_r <= 4'h0;
    end else begin
      cs_s1_r <= spi_cs_n_i;
      cs_s2_r <= cs_s1_r;
      ck_s1_r <= spi_sclk_i;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      ln_s1_r <= serial_lane_i;
      ln_s2_r <= ln_s1_r;
    end
  end

  assign rise_w = ck_s2_r & ~ck_s3_r;
  assign fall_w = ~ck_s2_r & ck_s3_r;

  // ==========================================================
  // configuration
  logic [2:0] wrap_r, wrap_nxt;
  logic [1:0] rp_r, rp_nxt;

  always_comb begin
    wrap_nxt = wrap_load_i ? wrap_settings_i : wrap_r;
    rp_nxt = read_param_load_i ? read_param_i : rp_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wrap_r <= mfre_pkg::WRAP_RESET;
      rp_r <= mfre_pkg::RDPARAM_RESET;
    end else begin
      wrap_r <= wrap_nxt;
      rp_r <= rp_nxt;
    end
  end

  // ==========================================================
  // frame sequencer
  mfre_pkg::mfre_state_t st_r, st_nxt;
  mfre_pkg::mfre_width_t in_w;
  logic [4:0] cnt_r, cnt_nxt;
  logic [31:0] sh_r, sh_nxt, sh_in_w;
  logic [7:0] cmd_r, cmd_nxt, oby_w, osh_r, osh_nxt, wmask_w, wlo_w;
  logic cont_r, cont_nxt, fetch_r, fetch_nxt, req_r, req_nxt, pend_r, pend_nxt;
  logic [23:0] fa_r, fa_nxt, fa_inc_w, fa_adv_w, maddr_r, maddr_nxt;
  logic [3:0] lane_r, lane_nxt, oe_r, oe_nxt;
  logic [2:0] ocnt_r, ocnt_nxt;
  logic act_r, qpi_w, dual_w, cmd_ok_w, wrap_on_w, mode_done_w, pop_w, push_w;
  logic [DATA_W-1:0] buf_r [BUF_DEPTH];
  logic [DATA_W-1:0] buf_nxt [BUF_DEPTH];
  logic [PW-1:0] wrp_r, wrp_nxt, rdp_r, rdp_nxt;
  logic [CW-1:0] bcnt_r, bcnt_nxt;
  logic rready_r, rready_nxt;

  function automatic logic [4:0] addr_clks(input logic [7:0] c);
    if (c == mfre_pkg::CMD_QUAD_OUT) begin
      return mfre_pkg::ADDR_CLK_X1;
    end else if (c == mfre_pkg::CMD_DUAL_IO) begin
      return mfre_pkg::ADDR_CLK_X2;
    end
    return mfre_pkg::ADDR_CLK_X4;
  endfunction

  assign qpi_w = four_wire_command_mode_i;
  assign dual_w = (cmd_r == mfre_pkg::CMD_DUAL_IO);
  assign mode_done_w = !cs_s2_r && st_r == mfre_pkg::ST_MODE && rise_w && cnt_r == 5'h00;
  assign oby_w = (bcnt_r != '0) ? buf_r[rdp_r] : mfre_pkg::UNDERRUN_BYTE;
  assign pop_w = !cs_s2_r && st_r == mfre_pkg::ST_DATA && fall_w && ocnt_r == 3'h0
                 && bcnt_r != '0;
  assign push_w = mem_rvalid_i && rready_r && fetch_r;

  // wrap only for the quad io reads in single-line command mode
  assign wrap_on_w = !wrap_r[mfre_pkg::WRAP_DIS_POS] && !qpi_w
                     && (cmd_r == mfre_pkg::CMD_QUAD_IO || cmd_r == mfre_pkg::CMD_WORD_QIO);
  assign wmask_w = 8'((mfre_pkg::WRAP_MIN_LEN << wrap_r[2:mfre_pkg::WRAP_LEN_LSB]) - 9'h001);
  assign fa_inc_w = fa_r + 24'h000001;
  assign wlo_w = (fa_r[7:0] & ~wmask_w) | (fa_inc_w[7:0] & wmask_w);
  assign fa_adv_w = wrap_on_w ? {fa_r[23:8], wlo_w} : fa_inc_w;

  always_comb begin
    if (st_r == mfre_pkg::ST_CMD) begin
      in_w = qpi_w ? mfre_pkg::LW_X4 : mfre_pkg::LW_X1;
    end else if (cmd_r == mfre_pkg::CMD_QUAD_OUT) begin
      in_w = mfre_pkg::LW_X1;
    end else if (dual_w) begin
      in_w = mfre_pkg::LW_X2;
    end else begin
      in_w = mfre_pkg::LW_X4;
    end
    unique case (in_w)
      mfre_pkg::LW_X1: sh_in_w = {sh_r[30:0], ln_s2_r[0]};
      mfre_pkg::LW_X2: sh_in_w = {sh_r[29:0], ln_s2_r[1:0]};
      default: sh_in_w = {sh_r[27:0], ln_s2_r};
    endcase
    cmd_ok_w = (sh_in_w[7:0] == mfre_pkg::CMD_QUAD_OUT && quad_lane_permit_bit_i && !qpi_w)
               || (sh_in_w[7:0] == mfre_pkg::CMD_DUAL_IO && !qpi_w)
               || (sh_in_w[7:0] == mfre_pkg::CMD_QUAD_IO && quad_lane_permit_bit_i)
               || (sh_in_w[7:0] == mfre_pkg::CMD_WORD_QIO && quad_lane_permit_bit_i && !qpi_w);
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    cmd_nxt = cmd_r;
    cont_nxt = cont_r;
    fa_nxt = fa_r;
    fetch_nxt = fetch_r;
    req_nxt = 1'b0;
    pend_nxt = pend_r;
    maddr_nxt = maddr_r;
    lane_nxt = lane_r;
    oe_nxt = oe_r;
    osh_nxt = osh_r;
    ocnt_nxt = ocnt_r;
    if (cs_s2_r) begin
      st_nxt = mfre_pkg::ST_IDLE;
      fetch_nxt = 1'b0;
      oe_nxt = 4'h0;
      ocnt_nxt = 3'h0;
    end else begin
      unique case (st_r)
        mfre_pkg::ST_IDLE: begin
          if (cont_r) begin
            st_nxt = mfre_pkg::ST_ADDR;
            cnt_nxt = addr_clks(cmd_r);
          end else begin
            st_nxt = mfre_pkg::ST_CMD;
            cnt_nxt = qpi_w ? mfre_pkg::CMD_CLK_QUAD : mfre_pkg::CMD_CLK_SINGLE;
          end
        end
        mfre_pkg::ST_CMD: begin
          if (rise_w) begin
            sh_nxt = sh_in_w;
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h00) begin
              cmd_nxt = sh_in_w[7:0];
              if (cmd_ok_w) begin
                st_nxt = mfre_pkg::ST_ADDR;
                cnt_nxt = addr_clks(sh_in_w[7:0]);
              end else begin
                st_nxt = mfre_pkg::ST_IGN;
              end
            end
          end
        end
        mfre_pkg::ST_ADDR: begin
          if (rise_w) begin
            sh_nxt = sh_in_w;
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h00) begin
              fa_nxt = sh_in_w[23:0];
              fetch_nxt = 1'b1;
              if (cmd_r == mfre_pkg::CMD_QUAD_OUT) begin
                st_nxt = mfre_pkg::ST_DUMMY;
                cnt_nxt = mfre_pkg::DUMMY_QUAD_OUT;
              end else begin
                st_nxt = mfre_pkg::ST_MODE;
                cnt_nxt = dual_w ? mfre_pkg::MODE_CLK_X2 : mfre_pkg::MODE_CLK_X4;
              end
            end
          end
        end
        mfre_pkg::ST_MODE: begin
          if (rise_w) begin
            sh_nxt = sh_in_w;
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h00) begin
              // only the select pair counts, low nibble ignored
              cont_nxt = (sh_in_w[mfre_pkg::MODE_SEL_LSB +: 2] == mfre_pkg::CONT_KEEP);
              if (dual_w) begin
                st_nxt = mfre_pkg::ST_DATA;
              end else if (qpi_w) begin
                st_nxt = (rp_r == 2'h0) ? mfre_pkg::ST_DATA : mfre_pkg::ST_DUMMY;
                cnt_nxt = {2'b00, rp_r, 1'b0} - 5'h01;
              end else if (cmd_r == mfre_pkg::CMD_WORD_QIO) begin
                st_nxt = mfre_pkg::ST_DUMMY;
                cnt_nxt = mfre_pkg::DUMMY_WORD_QIO;
              end else begin
                st_nxt = mfre_pkg::ST_DUMMY;
                cnt_nxt = mfre_pkg::DUMMY_QUAD_IO;
              end
            end
          end
        end
        mfre_pkg::ST_DUMMY: begin
          // lane values are not looked at here
          if (rise_w) begin
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h00) begin
              st_nxt = mfre_pkg::ST_DATA;
            end
          end
        end
        mfre_pkg::ST_DATA: begin
          if (fall_w) begin
            oe_nxt = dual_w ? mfre_pkg::OE_X2 : mfre_pkg::OE_X4;
            if (ocnt_r == 3'h0) begin
              lane_nxt = dual_w ? {2'b00, oby_w[7:6]} : oby_w[7:4];
              osh_nxt = dual_w ? {oby_w[5:0], 2'b00} : {oby_w[3:0], 4'h0};
              ocnt_nxt = dual_w ? mfre_pkg::OUT_BEATS_X2 : mfre_pkg::OUT_BEATS_X4;
            end else begin
              lane_nxt = dual_w ? {2'b00, osh_r[7:6]} : osh_r[7:4];
              osh_nxt = dual_w ? {osh_r[5:0], 2'b00} : {osh_r[3:0], 4'h0};
              ocnt_nxt = ocnt_r - 3'h1;
            end
          end
        end
        mfre_pkg::ST_IGN: begin
          oe_nxt = 4'h0;
        end
        default: st_nxt = mfre_pkg::ST_IDLE;
      endcase
    end
    // prefetch one byte at a time into the buffer
    if (mem_rvalid_i && rready_r) begin
      pend_nxt = 1'b0;
    end
    if (fetch_r && !cs_s2_r && !pend_r && !req_r && bcnt_r < CW'(BUF_DEPTH)) begin
      req_nxt = 1'b1;
      pend_nxt = 1'b1;
      maddr_nxt = fa_r;
      fa_nxt = fa_adv_w;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r <= mfre_pkg::ST_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 32'h00000000;
      cmd_r <= 8'h00;
      cont_r <= 1'b0;
      fa_r <= 24'h000000;
      fetch_r <= 1'b0;
      req_r <= 1'b0;
      pend_r <= 1'b0;
      maddr_r <= 24'h000000;
      lane_r <= 4'h0;
      oe_r <= 4'h0;
      osh_r <= 8'h00;
      ocnt_r <= 3'h0;
      act_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      cmd_r <= cmd_nxt;
      cont_r <= cont_nxt;
      fa_r <= fa_nxt;
      fetch_r <= fetch_nxt;
      req_r <= req_nxt;
      pend_r <= pend_nxt;
      maddr_r <= maddr_nxt;
      lane_r <= lane_nxt;
      oe_r <= oe_nxt;
      osh_r <= osh_nxt;
      ocnt_r <= ocnt_nxt;
      act_r <= (st_nxt != mfre_pkg::ST_IDLE);
    end
  end

  // ==========================================================
  // two-entry read buffer
  always_comb begin
    wrp_nxt = wrp_r;
    rdp_nxt = rdp_r;
    bcnt_nxt = bcnt_r;
    for (int i = 0; i < BUF_DEPTH; i++) begin
      buf_nxt[i] = buf_r[i];
    end
    if (cs_s2_r) begin
      wrp_nxt = '0;
      rdp_nxt = '0;
      bcnt_nxt = '0;
    end else begin
      if (push_w) begin
        buf_nxt[wrp_r] = mem_rdata_i;
        wrp_nxt = wrp_r + 1'b1;
      end
      if (pop_w) begin
        rdp_nxt = rdp_r + 1'b1;
      end
      bcnt_nxt = bcnt_r + CW'(push_w) - CW'(pop_w);
    end
    rready_nxt = (bcnt_nxt < CW'(BUF_DEPTH));
  end

  always_ff @(posedge sys_clk_i) begin
    buf_r <= buf_nxt;
    if (rst_i) begin
      wrp_r <= '0;
      rdp_r <= '0;
      bcnt_r <= '0;
      rready_r <= 1'b0;
    end else begin
      wrp_r <= wrp_nxt;
      rdp_r <= rdp_nxt;
      bcnt_r <= bcnt_nxt;
      rready_r <= rready_nxt;
    end
  end

  assign serial_lane_o = lane_r;
  assign serial_lane_oe_o = oe_r;
  assign read_active_o = act_r;
  assign execute_in_place_o = cont_r;
  assign wrap_settings_o = wrap_r;
  assign read_param_o = rp_r;
  assign mem_req_o = req_r;
  assign mem_addr_o = maddr_r;
  assign mem_rready_o = rready_r;

  // ==========================================================
  // assertions
  property p_release_on_cs;
    cs_s2_r |=> (serial_lane_oe_o == 4'h0);
  endproperty
  a_release_on_cs: assert property (p_release_on_cs) else $error("lanes driven while deselected");

  property p_ign_quiet;
    (st_r == mfre_pkg::ST_IGN) |-> (serial_lane_oe_o == 4'h0) && !mem_req_o;
  endproperty
  a_ign_quiet: assert property (p_ign_quiet) else $error("refused read drives lanes");

  property p_quad_needs_qe;
    (!cs_s2_r && st_r == mfre_pkg::ST_CMD && rise_w && cnt_r == 5'h00
     && sh_in_w[7:0] == mfre_pkg::CMD_QUAD_OUT && !quad_lane_permit_bit_i) |=> (st_r == mfre_pkg::ST_IGN);
  endproperty
  a_quad_needs_qe: assert property (p_quad_needs_qe) else $error("quad output taken without permit");

  property p_qpi_reject;
    (qpi_w && st_r == mfre_pkg::ST_CMD && cnt_r == 5'h00 && rise_w && !cs_s2_r
     && sh_in_w[7:0] == mfre_pkg::CMD_DUAL_IO) |=> (st_r == mfre_pkg::ST_IGN);
  endproperty
  a_qpi_reject: assert property (p_qpi_reject) else $error("dual io taken in four-wire mode");

  property p_quad_out_dummy;
    (st_r == mfre_pkg::ST_ADDR && st_nxt == mfre_pkg::ST_DUMMY)
      |=> (cnt_r == 5'h07) && (cmd_r == mfre_pkg::CMD_QUAD_OUT);
  endproperty
  a_quad_out_dummy: assert property (p_quad_out_dummy) else $error("wrong quad output dummy count");

  property p_quad_io_dummy;
    (st_r == mfre_pkg::ST_MODE && st_nxt == mfre_pkg::ST_DUMMY && !qpi_w)
      |=> (cnt_r == ((cmd_r == mfre_pkg::CMD_WORD_QIO) ? 5'h01 : 5'h03));
  endproperty
  a_quad_io_dummy: assert property (p_quad_io_dummy) else $error("wrong quad io dummy count");

  property p_qpi_dummy;
    (mode_done_w && qpi_w && !dual_w) |=> (st_r == mfre_pkg::ST_DATA) == (rp_r == 2'h0);
  endproperty
  a_qpi_dummy: assert property (p_qpi_dummy) else $error("four-wire dummy count wrong");

  property p_cont_keep;
    mode_done_w |=> (cont_r == ($past(sh_in_w[5:4]) == 2'b10));
  endproperty
  a_cont_keep: assert property (p_cont_keep) else $error("continuous select pair not honoured");

  property p_cont_skip;
    ($fell(cs_s2_r) && cont_r) |=> (st_r == mfre_pkg::ST_ADDR);
  endproperty
  a_cont_skip: assert property (p_cont_skip) else $error("continuous frame expects instruction");

  property p_wrap_section;
    (req_nxt && wrap_on_w && wrap_r[2:1] == 2'b00) |=> (fa_r[23:3] == $past(fa_r[23:3]));
  endproperty
  a_wrap_section: assert property (p_wrap_section) else $error("address left wrap section");

  property p_no_wrap_qpi;
    (req_nxt && qpi_w) |=> (fa_r == 24'($past(fa_r) + 24'h000001));
  endproperty
  a_no_wrap_qpi: assert property (p_no_wrap_qpi) else $error("four-wire read wrapped");

  property p_wrap_reset;
    $fell(rst_i) |-> wrap_r[0];
  endproperty
  a_wrap_reset: assert property (p_wrap_reset) else $error("wrap not disabled after reset");

  c_cont_frame: cover property ($fell(cs_s2_r) && cont_r);
  c_quad_pop: cover property (pop_w && !dual_w);
  c_wrap_turn: cover property (req_nxt && wrap_on_w && fa_adv_w[7:0] < fa_r[7:0]);
  c_buf_full: cover property (bcnt_r == CW'(BUF_DEPTH));
endmodule

// ==== sim/mfre_mem_model.sv ====
// array memory model answering byte reads after a set latency
`timescale 1ns/100ps
module mfre_mem_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // read port
  input wire logic req_i,
  input wire logic [23:0] addr_i,
  input wire logic rready_i,
  output logic rvalid_o,
  output logic [7:0] rdata_o
);
  // ==========================================================
  // one outstanding read, held until taken
  logic [7:0] byte_r;
  int wait_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 0;
      rvalid_o <= 1'b0;
      byte_r <= 8'h00;
    end else if (req_i) begin
      wait_r <= LAT;
      byte_r <= addr_i[7:0] ^ 8'h5A;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
    end else if (wait_r == 1) begin
      rvalid_o <= 1'b1;
      wait_r <= 0;
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end
  end
  // stale data is never shown
  assign rdata_o = rvalid_o ? byte_r : ~byte_r;
endmodule

// ==== sim/mfre_engine_tb_top.sv ====
// bench for the multi-line fast read engine
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t %s", $time, m); end end
module mfre_engine_tb_top;
  // ==========================================================
  // pins and bench state
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  logic [3:0] host_lane = 4'h0;
  logic [3:0] lane_o, lane_oe, lane_w;
  logic permit = 1'b1;
  logic four_wire = 1'b0;
  logic wrap_ld = 1'b0;
  logic [2:0] wrap_set = 3'h1;
  logic rp_ld = 1'b0;
  logic [1:0] rp = 2'h0;
  logic active, execute_in_place, req, rvalid, rready;
  logic [2:0] wrap_q;
  logic [1:0] rp_q;
  logic [23:0] maddr;
  logic [7:0] rdata;
  logic saw_full = 1'b0;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // wire level from both parties
  assign lane_w = (lane_oe & lane_o) | (~lane_oe & host_lane);
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // design and memory
  mfre_engine u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .serial_lane_i(lane_w), .serial_lane_o(lane_o),
    .serial_lane_oe_o(lane_oe), .quad_lane_permit_bit_i(permit),
    .four_wire_command_mode_i(four_wire), .wrap_load_i(wrap_ld), .wrap_settings_i(wrap_set),
    .read_param_load_i(rp_ld), .read_param_i(rp), .read_active_o(active),
    .execute_in_place_o(execute_in_place), .wrap_settings_o(wrap_q), .read_param_o(rp_q),
    .mem_req_o(req), .mem_addr_o(maddr), .mem_rdata_i(rdata), .mem_rvalid_i(rvalid),
    .mem_rready_o(rready));
  mfre_mem_model u_mem (.clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .addr_i(maddr),
    .rready_i(rready), .rvalid_o(rvalid), .rdata_o(rdata));
  // ==========================================================
  // watchdog and buffer watch
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (active === 1'b1 && rready === 1'b0) saw_full <= 1'b1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // serial access tasks
  task automatic tick(input logic [3:0] dv, output logic [3:0] q, output logic [3:0] oe);
    host_lane <= dv;
    repeat (4) @(posedge sys_clk_i);
    q = lane_w;
    oe = lane_oe;
    sclk <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    sclk <= 1'b0;
  endtask
  task automatic shift(input logic [31:0] v, input int nb, input int w);
    logic [3:0] q, oe;
    for (int k = nb / w - 1; k >= 0; k--) tick(4'((v >> (k * w)) & ((1 << w) - 1)), q, oe);
  endtask
  task automatic frame(input string nm, input logic [7:0] cmd, input int cw,
      input logic [23:0] a, input int aw, input logic [7:0] m, input int mw, input int nd,
      input int dw, input int nb, input int wl, input logic on);
    logic [3:0] q, oe;
    logic [7:0] got;
    logic [23:0] ea;
    ea = a;
    @(posedge sys_clk_i);
    cs_n <= 1'b0;
    if (cw > 0) shift(32'(cmd), 8, cw);
    shift(32'(a), 24, aw);
    // mw counts mode clocks: four on two lanes, two on four lanes
    if (mw > 0) shift(32'(m), 8, 8 / mw);
    repeat (nd) tick(~host_lane, q, oe);
    for (int b = 0; b < nb; b++) begin
      got = 8'h00;
      for (int k = 0; k < 8 / dw; k++) begin
        tick(~host_lane, q, oe);
        got = (got << dw) | 8'(q & 4'((1 << dw) - 1));
        `CHK(oe, on ? 4'((1 << dw) - 1) : 4'h0, "lane enables")
      end
      if (on) `CHK(got, ea[7:0] ^ 8'h5A, "data byte")
      ea = (wl > 0) ? ((ea & ~24'(wl - 1)) | ((ea + 24'h1) & 24'(wl - 1))) : ea + 24'h1;
    end
    @(posedge sys_clk_i);
    `CHK(active, 1'b1, "active in frame")
    cs_n <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    `CHK(lane_oe, 4'h0, "released after deselect")
    `CHK(active, 1'b0, "idle after deselect")
    $display("test %s done", nm);
  endtask
  // ==========================================================
  // test sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    `CHK(wrap_q, 3'h1, "wrap reset")
    `CHK(rp_q, 2'h0, "param reset")
    frame("quad_out", mfre_pkg::CMD_QUAD_OUT, 1, 24'h012345, 1, 8'h00, 0, 8, 4, 3, 0, 1);
    permit <= 1'b0;
    frame("qo_off", mfre_pkg::CMD_QUAD_OUT, 1, 24'h000010, 1, 8'h00, 0, 8, 4, 2, 0, 0);
    frame("qio_off", mfre_pkg::CMD_QUAD_IO, 1, 24'h000020, 4, 8'h00, 2, 4, 4, 2, 0, 0);
    frame("wq_off", mfre_pkg::CMD_WORD_QIO, 1, 24'h000030, 4, 8'h00, 2, 2, 4, 2, 0, 0);
    permit <= 1'b1;
    frame("dual_io", mfre_pkg::CMD_DUAL_IO, 1, 24'h0300FE, 2, 8'h2F, 4, 0, 2, 3, 0, 1);
    `CHK(execute_in_place, 1'b1, "dual continuous armed")
    frame("dual_exit", 8'h00, 0, 24'h555555, 2, 8'h55, 4, 0, 2, 1, 0, 1);
    `CHK(execute_in_place, 1'b0, "dual continuous left")
    wrap_set <= 3'h0;
    wrap_ld <= 1'b1;
    @(posedge sys_clk_i);
    wrap_ld <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    `CHK(wrap_q, 3'h0, "wrap loaded")
    frame("qio_wrap", mfre_pkg::CMD_QUAD_IO, 1, 24'h000106, 4, 8'h20, 2, 4, 4, 4, 8, 1);
    `CHK(execute_in_place, 1'b1, "quad continuous armed")
    frame("qio_exit", 8'h00, 0, 24'h111111, 4, 8'h11, 2, 4, 4, 2, 8, 1);
    `CHK(execute_in_place, 1'b0, "quad continuous left")
    frame("word_qio", mfre_pkg::CMD_WORD_QIO, 1, 24'h00020E, 4, 8'h00, 2, 2, 4, 3, 8, 1);
    four_wire <= 1'b1;
    frame("qpi_nowrap", mfre_pkg::CMD_QUAD_IO, 4, 24'h00003E, 4, 8'h00, 2, 0, 4, 3, 0, 1);
    rp <= 2'h3;
    rp_ld <= 1'b1;
    @(posedge sys_clk_i);
    rp_ld <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    `CHK(rp_q, 2'h3, "param loaded")
    frame("qpi_param", mfre_pkg::CMD_QUAD_IO, 4, 24'h000500, 4, 8'h20, 2, 6, 4, 2, 0, 1);
    `CHK(execute_in_place, 1'b1, "qpi continuous armed")
    frame("qpi_cont", 8'h00, 0, 24'h000600, 4, 8'hFF, 2, 6, 4, 1, 0, 1);
    `CHK(execute_in_place, 1'b0, "qpi continuous left")
    frame("qpi_dual", mfre_pkg::CMD_DUAL_IO, 4, 24'h000700, 2, 8'h00, 4, 0, 2, 1, 0, 0);
    frame("qpi_qo", mfre_pkg::CMD_QUAD_OUT, 4, 24'h000710, 1, 8'h00, 0, 8, 4, 1, 0, 0);
    `CHK(saw_full, 1'b1, "buffer filled")
    close_out();
  end
endmodule
